/* File: shared/brc_pkg.sv */
// package of constants and types for the 4-bit binary ripple counter
// Contract
// (R1) one divide-by-two stage plus divide-by-eight stage
// (R2) each stage advances on its clock's falling edge
// (R3) users avoid decoded count bits as clocks
// (R4) both clears high force all bits low
// (R5) user wires first output to upper clock
// (R6) 4-bit mode divides by 2,4,8,16
// (R7) 3-bit mode divides by 2,4,8
// (R8) lone toggle stage shares reset with upper
// (R9) 4-bit mode counts zero to fifteen, wraps
// (R10) clear acts at once; count resumes next edge; count goes to zero three enabled clk edges after both clears rise
package brc_pkg;
	localparam int unsigned UPPER_WIDTH = 3;
	localparam logic                   FIRST_RESET = 1'h0;
	localparam logic [UPPER_WIDTH-1:0] UPPER_RESET = 3'h0;
	localparam logic [UPPER_WIDTH-1:0] UPPER_STEP  = 3'h1;
	localparam logic [1:0]             SYNC_RESET  = 2'h0;
	localparam logic                   EDGE_LAST_RESET = 1'h0;

	// all state of the counter
	typedef struct packed {
		logic [1:0]             firstClkSync;
		logic [1:0]             upperClkSync;
		logic [1:0]             clearASync;
		logic [1:0]             clearBSync;
		logic                   firstClkLast;
		logic                   upperClkLast;
		logic                   firstBit;
		logic [UPPER_WIDTH-1:0] upperBits;
	} brc_state_s;
endpackage : brc_pkg

/* File: rtl/brc_counter.sv */
// 4-bit binary ripple counter: divide-by-two and divide-by-eight stages
`timescale 1ns/1ps
module brc_counter (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clkEn,
	input  wire logic clear_input_a,
	input  wire logic clear_input_b,
	input  wire logic first_stage_clock_n,
	input  wire logic upper_stage_clock_n,
	output logic      count_bit_zero,
	output logic      count_bit_one,
	output logic      count_bit_two,
	output logic      count_bit_three
);
	brc_pkg::brc_state_s state_q;
	brc_pkg::brc_state_s state_d;
	logic                clearNow;
	logic                firstFall;
	logic                upperFall;

	// the upper stage feeds exactly three output pins
	if (brc_pkg::UPPER_WIDTH != 3) begin : widthCheck
		$error("upper stage width must be three");
	end

	always_comb begin
		state_d = state_q;
		// pins pass two flops; only stage two is read by logic
		state_d.firstClkSync = {state_q.firstClkSync[0], first_stage_clock_n};
		state_d.upperClkSync = {state_q.upperClkSync[0], upper_stage_clock_n};
		state_d.clearASync   = {state_q.clearASync[0], clear_input_a};
		state_d.clearBSync   = {state_q.clearBSync[0], clear_input_b};
		state_d.firstClkLast = state_q.firstClkSync[1];
		state_d.upperClkLast = state_q.upperClkSync[1];
		clearNow  = state_q.clearASync[1] & state_q.clearBSync[1]; // see (R4)
		firstFall = state_q.firstClkLast & ~state_q.firstClkSync[1]; // see (R2)
		upperFall = state_q.upperClkLast & ~state_q.upperClkSync[1]; // see (R2)
		if (clearNow) begin
			// clear overrides both clocks; clears whole counter together, see (R8)
			state_d.firstBit  = brc_pkg::FIRST_RESET; // see (R4) (R10)
			state_d.upperBits = brc_pkg::UPPER_RESET; // see (R4) (R10)
		end else begin
			// separate stages; upper clock wired externally for 4-bit, see (R1) (R5)
			if (firstFall) begin
				state_d.firstBit = ~state_q.firstBit; // see (R6)
			end
			if (upperFall) begin
				state_d.upperBits = state_q.upperBits + brc_pkg::UPPER_STEP; // see (R7) (R9)
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q.firstClkSync <= brc_pkg::SYNC_RESET;
			state_q.upperClkSync <= brc_pkg::SYNC_RESET;
			state_q.clearASync   <= brc_pkg::SYNC_RESET;
			state_q.clearBSync   <= brc_pkg::SYNC_RESET;
			state_q.firstClkLast <= brc_pkg::EDGE_LAST_RESET;
			state_q.upperClkLast <= brc_pkg::EDGE_LAST_RESET;
			state_q.firstBit     <= brc_pkg::FIRST_RESET;
			state_q.upperBits    <= brc_pkg::UPPER_RESET;
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	// outputs come straight from state flops; may settle apart, see (R3)
	assign count_bit_zero  = state_q.firstBit;
	assign count_bit_one   = state_q.upperBits[0];
	assign count_bit_two   = state_q.upperBits[1];
	assign count_bit_three = state_q.upperBits[2];

	// the count as one word, bit zero least significant, for the checks below
	logic [3:0] countView;
	assign countView = {count_bit_three, count_bit_two, count_bit_one, count_bit_zero};

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// clear path: both clears high zero every stage and win over any edge
	clear_forces_zero_a: assert property ( // see (R4)
		clkEn && clearNow
		|=> countView == 4'h0)
		else $error("clear did not zero the count");

	clear_sync_a: assert property ( // see (R4)
		(clkEn && clear_input_a && clear_input_b) [*3]
		|=> countView == 4'h0)
		else $error("held clear did not reach the count");

	clear_beats_first_a: assert property ( // see (R4)
		clkEn && clearNow && firstFall
		|=> !count_bit_zero)
		else $error("first stage counted during clear");

	clear_beats_upper_a: assert property ( // see (R4)
		clkEn && clearNow && upperFall
		|=> state_q.upperBits == 3'h0)
		else $error("upper stage counted during clear");

	clear_a_low_a: assert property ( // see (R4)
		clkEn && firstFall && !state_q.clearASync[1]
		|=> count_bit_zero != $past(count_bit_zero))
		else $error("first stage held although one clear was low");

	clear_b_low_a: assert property ( // see (R4)
		clkEn && upperFall && !state_q.clearBSync[1]
		|=> state_q.upperBits == $past(state_q.upperBits) + 3'h1)
		else $error("upper stage held although one clear was low");

	// release of clear: zero stands until the first counted edge
	clear_holds_zero_a: assert property ( // see (R10)
		clkEn && clearNow ##1 clkEn && !clearNow && !firstFall && !upperFall
		|=> countView == 4'h0)
		else $error("count left zero without an edge after clear");

	first_resume_a: assert property ( // see (R10)
		clkEn && clearNow ##1 clkEn && !clearNow && firstFall
		|=> count_bit_zero)
		else $error("first stage did not resume after clear");

	upper_resume_a: assert property ( // see (R10)
		clkEn && clearNow ##1 clkEn && !clearNow && upperFall
		|=> state_q.upperBits == 3'h1)
		else $error("upper stage did not resume after clear");

	// first stage: toggles once per falling edge of its own clock
	first_toggles_a: assert property ( // see (R2)
		clkEn && firstFall && !clearNow
		|=> count_bit_zero != $past(count_bit_zero))
		else $error("first stage missed a falling edge");

	first_holds_a: assert property ( // see (R2)
		clkEn && !firstFall && !clearNow
		|=> $stable(count_bit_zero))
		else $error("first stage moved without an edge");

	first_divides_a: assert property ( // see (R6)
		clkEn && firstFall && !clearNow && count_bit_zero
		|=> !count_bit_zero)
		else $error("first stage did not return low");

	first_pin_latency_a: assert property ( // see (R2)
		clkEn ##1 clkEn && $fell(first_stage_clock_n) ##1 clkEn ##1 clkEn && !clearNow
		|=> count_bit_zero != $past(count_bit_zero))
		else $error("first pin fall did not toggle the count in time");

	stages_apart_a: assert property ( // see (R1)
		clkEn && upperFall && !firstFall && !clearNow
		|=> $stable(count_bit_zero))
		else $error("upper edge moved the first stage");

	// upper stage: steps through zero to seven on each falling edge, then wraps
	upper_steps_a: assert property ( // see (R9)
		clkEn && upperFall && !clearNow
		|=> state_q.upperBits == $past(state_q.upperBits) + 3'h1)
		else $error("upper stage did not step by one");

	upper_holds_a: assert property ( // see (R7)
		clkEn && !upperFall && !clearNow
		|=> $stable(state_q.upperBits))
		else $error("upper stage moved without an edge");

	upper_wraps_a: assert property ( // see (R9)
		clkEn && upperFall && !clearNow && state_q.upperBits == 3'h7
		|=> state_q.upperBits == 3'h0)
		else $error("upper stage did not wrap");

	upper_pin_latency_a: assert property ( // see (R7)
		clkEn ##1 clkEn && $fell(upper_stage_clock_n) ##1 clkEn ##1 clkEn && !clearNow
		|=> state_q.upperBits == $past(state_q.upperBits) + 3'h1)
		else $error("upper pin fall did not step the count in time");

	// pin synchronisers shift once per enabled cycle; only stage two feeds logic
	sync_first_a: assert property ( // see (R2)
		clkEn |=> state_q.firstClkSync[1] == $past(state_q.firstClkSync[0])
			&& state_q.firstClkSync[0] == $past(first_stage_clock_n))
		else $error("first clock synchroniser did not shift");

	sync_upper_a: assert property ( // see (R2)
		clkEn |=> state_q.upperClkSync[1] == $past(state_q.upperClkSync[0])
			&& state_q.upperClkSync[0] == $past(upper_stage_clock_n))
		else $error("upper clock synchroniser did not shift");

	sync_clear_a: assert property ( // see (R4)
		clkEn |=> state_q.clearASync[1] == $past(state_q.clearASync[0])
			&& state_q.clearBSync[1] == $past(state_q.clearBSync[0]))
		else $error("clear synchroniser did not shift");

	edge_last_a: assert property ( // see (R2)
		clkEn |=> state_q.firstClkLast == $past(state_q.firstClkSync[1])
			&& state_q.upperClkLast == $past(state_q.upperClkSync[1]))
		else $error("edge detector lost its last sample");

	// freeze and reset
	freeze_hold_a: assert property ( // see (R10)
		!clkEn
		|=> $stable(state_q))
		else $error("state moved while clock enable low");

	reset_zero_a: assert property ( // see (R10)
		@(posedge clk) disable iff (1'h0)
		rst |=> countView == 4'h0)
		else $error("reset did not zero the count");

	reset_sync_a: assert property ( // see (R10)
		@(posedge clk) disable iff (1'h0)
		rst |=> state_q.firstClkSync == brc_pkg::SYNC_RESET
			&& state_q.upperClkSync == brc_pkg::SYNC_RESET
			&& state_q.clearASync == brc_pkg::SYNC_RESET)
		else $error("reset did not clear the synchronisers");

	// main scenarios worth seeing at least once
	clear_c:   cover property (clkEn && clearNow);
	wrap_c:    cover property (clkEn && upperFall && state_q.upperBits == 3'h7);
	toggle_c:  cover property (clkEn && firstFall && count_bit_zero);
	resume_c:  cover property (clkEn && clearNow ##1 clkEn && !clearNow && upperFall);
	freeze_c:  cover property (!clkEn && firstFall);
endmodule : brc_counter

/* File: test/brc_pulser.sv */
// count pulse source: per pulse low 4 cycles then high 4 cycles while go
`timescale 1ns/1ps
module brc_pulser (
	input  wire logic clk,
	input  wire logic go,
	output logic      pulseN
);
	logic [2:0] phase = 3'h0;
	always @(posedge clk) phase <= go ? phase + 3'h1 : 3'h0;
	assign pulseN = !(go && !phase[2]);
endmodule : brc_pulser

/* File: test/brc_counter_bench.sv */
// self-checking bench of the ripple counter
`timescale 1ns/1ps
module brc_counter_bench;
	logic       clk = 1'h0, rst = 1'h1, clkEn = 1'h1, clrA = 1'h0, clrB = 1'h0;
	logic       go = 1'h0, mode4 = 1'h0, pulseN;
	logic [3:0] q;
	logic [9:0] rows [8] = '{10'h036, 10'h07E, 10'h080, 10'h211, 10'h255, 10'h2FF, 10'h300, 10'h311};
	int         mismatches = 0, checked = 0;
	always #2.5 clk = ~clk;
	brc_pulser brc_pulser_inst (.clk(clk), .go(go), .pulseN(pulseN));
	brc_counter brc_counter_inst (.clk(clk), .rst(rst), .clkEn(clkEn), .clear_input_a(clrA),
		.clear_input_b(clrB), .first_stage_clock_n(mode4 ? pulseN : 1'h1),
		.upper_stage_clock_n(mode4 ? q[0] : pulseN), .count_bit_zero(q[0]),
		.count_bit_one(q[1]), .count_bit_two(q[2]), .count_bit_three(q[3]));
	task automatic check(input logic [3:0] seen, input logic [3:0] want);
		checked++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %0t count %h expected %h", $time, seen, want);
		end
	endtask : check
	// clears settle before the first pulse so no fall meets a clear release
	task automatic step(input logic a, input logic b, input int n);
		clrA <= a;
		clrB <= b;
		repeat (4) @(posedge clk);
		if (n > 0) go <= 1'h1;
		repeat (8 * n) @(posedge clk);
		go <= 1'h0;
		repeat (12) @(posedge clk);
	endtask : step
	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		foreach (rows[i]) begin
			mode4 <= rows[i][9];
			step(1'h1, 1'h1, 0);
			step(1'h0, 1'h0, int'(rows[i][8:4]));
			check(q, rows[i][3:0]);
		end
		step(1'h0, 1'h1, 3);
		check(q, 4'h4);
		step(1'h1, 1'h1, 0);
		check(q, 4'h0);
		step(1'h1, 1'h0, 1);
		check(q, 4'h1);
		clkEn <= 1'h0;
		step(1'h0, 1'h0, 2);
		check(q, 4'h1);
		clkEn <= 1'h1;
		step(1'h0, 1'h0, 2);
		check(q, 4'h3);
		rst <= 1'h1;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		check(q, 4'h0);
		step(1'h0, 1'h0, 1);
		check(q, 4'h1);
		summarize();
	end
endmodule : brc_counter_bench
